// *** dac_ctl_pkg.sv ***
// Shared constants and types for the range and code DAC control link
package dac_ctl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int UPD_PULSE_NS  = 80;
  localparam int UPD_PULSE_CYC = (UPD_PULSE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int GAP_CYC       = 2 * SCK_HALF_CYC;

  localparam int FRAME_BITS = 32;
  localparam int CMD_BITS   = 8;
  localparam int DATA_BITS  = 24;
  localparam int CODE_BITS  = 18;
  localparam int SPAN_BITS  = 4;
  // Span sits in the low nibble of the second data byte
  localparam int SPAN_POS   = 8;
  localparam int CODE_POS   = DATA_BITS - CODE_BITS;
  localparam int CMD_POS    = FRAME_BITS - 4;

  localparam logic [3:0] CMD_WR_SPAN  = 4'h2;
  localparam logic [3:0] CMD_WR_CODE  = 4'h3;
  localparam logic [3:0] CMD_UPDATE   = 4'h4;
  localparam logic [3:0] CMD_WSPAN_UP = 4'h6;
  localparam logic [3:0] CMD_WCODE_UP = 4'h7;
  localparam logic [3:0] CMD_RD_ISPAN = 4'ha;
  localparam logic [3:0] CMD_RD_ICODE = 4'hb;
  localparam logic [3:0] CMD_RD_DSPAN = 4'hc;
  localparam logic [3:0] CMD_RD_DCODE = 4'hd;
  localparam logic [3:0] CMD_NOP      = 4'hf;

  localparam logic [3:0] SPAN_U5    = 4'h0;
  localparam logic [3:0] SPAN_U10   = 4'h1;
  localparam logic [3:0] SPAN_B5    = 4'h2;
  localparam logic [3:0] SPAN_B10   = 4'h3;
  localparam logic [3:0] SPAN_B2P5  = 4'h4;
  localparam logic [3:0] SPAN_OFF25 = 4'h5;

  localparam logic [3:0]           SPAN_RST = SPAN_U5;
  localparam logic [CODE_BITS-1:0] CODE_RST = 18'h00000;

  // Pin positions in the synchronised input vector
  localparam int PIN_SELN   = 10;
  localparam int PIN_SCK    = 9;
  localparam int PIN_SDI    = 8;
  localparam int PIN_UPDN   = 7;
  localparam int PIN_CLRN   = 6;
  localparam int PIN_SUPLO  = 5;
  localparam int PIN_MANUAL = 4;
  localparam int PIN_COUNT  = 11;
  localparam logic [PIN_COUNT-1:0] PIN_RST = 11'h4c0;

  typedef enum logic [1:0] {
    PTR_IN_SPAN,
    PTR_IN_CODE,
    PTR_DAC_SPAN,
    PTR_DAC_CODE
  } rb_ptr_e;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_LOW,
    H_HIGH,
    H_HOLD,
    H_GAP,
    H_UPD
  } host_state_e;
endpackage

// *** dac_link_if.sv ***
// Serial link between the host and the DAC control logic
`timescale 1ns/1ps
interface dac_link_if;
  logic selectLoadN;
  logic sck;
  logic sdi;
  logic serialReadbackOut;
  logic sroOe;
  logic asyncUpdateN;
  logic systemClearN;
  logic integrityFlagN;

  modport dev (
    input  selectLoadN, sck, sdi, asyncUpdateN, systemClearN,
    output serialReadbackOut, sroOe, integrityFlagN
  );
  modport host (
    output selectLoadN, sck, sdi, asyncUpdateN, systemClearN,
    input  serialReadbackOut, sroOe, integrityFlagN
  );
endinterface

// *** dac_range_code_control.sv ***
// Device end: serial command decode, input and DAC registers, readback
`timescale 1ns/1ps
module dac_range_code_control
  import dac_ctl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  dac_link_if.dev                   link,
  input  wire logic                 manualSpan,
  input  wire logic                 rangeCodeBit3,
  input  wire logic                 rangeCodeBit2,
  input  wire logic                 rangeCodeBit1,
  input  wire logic                 rangeCodeBit0,
  input  wire logic                 supplyLow,
  output logic      [CODE_BITS-1:0] dacCode,
  output logic      [SPAN_BITS-1:0] dacSpan,
  output logic signed [15:0]        rangeMinMv,
  output logic signed [15:0]        rangeMaxMv
);
  logic [PIN_COUNT-1:0]  pinMeta, pinSync, pinPrev;
  logic [FRAME_BITS-1:0] shiftIn, next_shiftIn;
  logic [5:0]            bitCnt, next_bitCnt;
  logic [DATA_BITS-1:0]  rbShift, next_rbShift;
  rb_ptr_e               rbPtr, next_rbPtr;
  logic [CODE_BITS-1:0]  inputCode, next_inputCode, next_dacCode;
  logic [SPAN_BITS-1:0]  inputSpan, next_inputSpan, next_dacSpan;
  logic [SPAN_BITS-1:0]  strap;
  logic                  aborted, next_aborted;
  logic                  flagN, next_flagN;
  logic                  sroOut, next_sroOut;
  logic                  sroOe, next_sroOe;
  logic signed [15:0]    next_rangeMinMv, next_rangeMaxMv;
  logic                  selN, selFall, selRise;
  logic                  sckRise, sckFall, updPinFall;
  logic                  clrActive, doUpdate;
  logic [3:0]            cmd;
  logic [7:0]            cmdByte;

  assign selN       = pinSync[PIN_SELN];
  assign selFall    = pinPrev[PIN_SELN] & ~selN;
  assign selRise    = ~pinPrev[PIN_SELN] & selN;
  assign sckRise    = ~pinPrev[PIN_SCK] & pinSync[PIN_SCK];
  assign sckFall    = pinPrev[PIN_SCK] & ~pinSync[PIN_SCK];
  assign updPinFall = pinPrev[PIN_UPDN] & ~pinSync[PIN_UPDN];
  assign clrActive  = ~pinSync[PIN_CLRN];
  assign strap      = pinSync[SPAN_BITS-1:0];
  assign cmd        = shiftIn[CMD_POS +: 4];
  assign cmdByte    = {shiftIn[CMD_BITS-2:0], pinSync[PIN_SDI]};

  function automatic logic spanValid(input logic [SPAN_BITS-1:0] s);
    return s <= SPAN_OFF25;
  endfunction

  function automatic logic [DATA_BITS-1:0] rbWord(input rb_ptr_e p);
    logic [DATA_BITS-1:0] w;
    w = '0;
    case (p)
      PTR_IN_SPAN:  w[SPAN_POS +: SPAN_BITS] = inputSpan;
      PTR_IN_CODE:  w[CODE_POS +: CODE_BITS] = inputCode;
      PTR_DAC_SPAN: w[SPAN_POS +: SPAN_BITS] = dacSpan;
      PTR_DAC_CODE: w[CODE_POS +: CODE_BITS] = dacCode;
      default:      w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    next_shiftIn    = shiftIn;
    next_bitCnt     = bitCnt;
    next_rbShift    = rbShift;
    next_rbPtr      = rbPtr;
    next_inputCode  = inputCode;
    next_inputSpan  = inputSpan;
    next_dacCode    = dacCode;
    next_dacSpan    = dacSpan;
    next_aborted    = aborted;
    next_flagN      = flagN;
    next_sroOut     = sroOut;
    next_sroOe      = sroOe;
    doUpdate        = 1'b0;
    if (selFall) begin
      next_bitCnt  = '0;
      next_aborted = 1'b0;
      next_sroOe   = 1'b1;
      next_sroOut  = 1'b0;
    end
    if (!selN && sckRise && bitCnt < 6'(FRAME_BITS)) begin
      next_shiftIn = {shiftIn[FRAME_BITS-2:0], pinSync[PIN_SDI]};
      next_bitCnt  = bitCnt + 6'd1;
      if (bitCnt == 6'(CMD_BITS - 1)) begin
        case (cmdByte[7:4])
          CMD_RD_ISPAN: next_rbShift = rbWord(PTR_IN_SPAN);
          CMD_RD_ICODE: next_rbShift = rbWord(PTR_IN_CODE);
          CMD_RD_DSPAN: next_rbShift = rbWord(PTR_DAC_SPAN);
          CMD_RD_DCODE: next_rbShift = rbWord(PTR_DAC_CODE);
          default:      next_rbShift = rbWord(rbPtr);
        endcase
      end
    end
    if (!selN && sckFall && bitCnt >= 6'(CMD_BITS)
        && bitCnt < 6'(FRAME_BITS)) begin
      next_sroOut  = rbShift[DATA_BITS-1];
      next_rbShift = {rbShift[DATA_BITS-2:0], 1'b0};
    end
    if (selRise) begin
      next_sroOe  = 1'b0;
      next_sroOut = 1'b0;
      if (bitCnt == 6'(FRAME_BITS) && !aborted && !clrActive) begin
        case (cmd)
          CMD_WR_SPAN: begin
            if (spanValid(shiftIn[SPAN_POS +: SPAN_BITS]))
              next_inputSpan = shiftIn[SPAN_POS +: SPAN_BITS];
            next_rbPtr = PTR_IN_SPAN;
          end
          CMD_WR_CODE: begin
            next_inputCode = shiftIn[CODE_POS +: CODE_BITS];
            next_rbPtr     = PTR_IN_CODE;
          end
          CMD_UPDATE: begin
            doUpdate   = 1'b1;
            next_rbPtr = PTR_DAC_SPAN;
          end
          CMD_WSPAN_UP: begin
            if (spanValid(shiftIn[SPAN_POS +: SPAN_BITS]))
              next_inputSpan = shiftIn[SPAN_POS +: SPAN_BITS];
            doUpdate   = 1'b1;
            next_rbPtr = PTR_DAC_SPAN;
          end
          CMD_WCODE_UP: begin
            next_inputCode = shiftIn[CODE_POS +: CODE_BITS];
            doUpdate       = 1'b1;
            next_rbPtr     = PTR_DAC_CODE;
          end
          CMD_RD_ISPAN: next_rbPtr = PTR_IN_SPAN;
          CMD_RD_ICODE: next_rbPtr = PTR_IN_CODE;
          CMD_RD_DSPAN: next_rbPtr = PTR_DAC_SPAN;
          CMD_RD_DCODE: next_rbPtr = PTR_DAC_CODE;
          CMD_NOP:      next_rbPtr = PTR_DAC_CODE;
          default:      next_rbPtr = rbPtr;
        endcase
      end
    end
    // update pin, locked out while selected
    if (updPinFall && selN && !selRise)
      doUpdate = 1'b1;
    if (doUpdate) begin
      next_dacCode = next_inputCode;
      next_dacSpan = pinSync[PIN_MANUAL] ? strap : next_inputSpan;
      next_flagN   = 1'b1;
    end
    // clear zeroes DAC registers; inputs untouched
    if (clrActive) begin
      next_dacCode = CODE_RST;
      next_dacSpan = SPAN_RST;
      next_flagN   = 1'b0;
      next_rbPtr   = PTR_DAC_SPAN;
      if (!selN)
        next_aborted = 1'b1;
    end
    if (pinSync[PIN_SUPLO])
      next_flagN = 1'b0;
  end

  always_comb begin
    case (dacSpan)
      SPAN_U5, SPAN_U10:     next_rangeMinMv = 16'sd0;
      SPAN_B5:               next_rangeMinMv = -16'sd5000;
      SPAN_B10:              next_rangeMinMv = -16'sd10000;
      SPAN_B2P5, SPAN_OFF25: next_rangeMinMv = -16'sd2500;
      default:               next_rangeMinMv = 16'sd0;
    endcase
    case (dacSpan)
      SPAN_U5, SPAN_B5:      next_rangeMaxMv = 16'sd5000;
      SPAN_U10, SPAN_B10:    next_rangeMaxMv = 16'sd10000;
      SPAN_B2P5:             next_rangeMaxMv = 16'sd2500;
      SPAN_OFF25:            next_rangeMaxMv = 16'sd7500;
      default:               next_rangeMaxMv = 16'sd5000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta    <= PIN_RST;
      pinSync    <= PIN_RST;
      pinPrev    <= PIN_RST;
      shiftIn    <= '0;
      bitCnt     <= '0;
      rbShift    <= '0;
      rbPtr      <= PTR_DAC_SPAN;
      inputCode  <= CODE_RST;
      inputSpan  <= SPAN_RST;
      dacCode    <= CODE_RST;
      dacSpan    <= SPAN_RST;
      aborted    <= 1'b0;
      flagN      <= 1'b0;
      sroOut     <= 1'b0;
      sroOe      <= 1'b0;
      rangeMinMv <= 16'sd0;
      rangeMaxMv <= 16'sd5000;
    end else begin
      pinMeta    <= {link.selectLoadN, link.sck, link.sdi,
                     link.asyncUpdateN, link.systemClearN, supplyLow,
                     manualSpan, rangeCodeBit3, rangeCodeBit2,
                     rangeCodeBit1, rangeCodeBit0};
      pinSync    <= pinMeta;
      pinPrev    <= pinSync;
      shiftIn    <= next_shiftIn;
      bitCnt     <= next_bitCnt;
      rbShift    <= next_rbShift;
      rbPtr      <= next_rbPtr;
      inputCode  <= next_inputCode;
      inputSpan  <= next_inputSpan;
      dacCode    <= next_dacCode;
      dacSpan    <= next_dacSpan;
      aborted    <= next_aborted;
      flagN      <= next_flagN;
      sroOut     <= next_sroOut;
      sroOe      <= next_sroOe;
      rangeMinMv <= next_rangeMinMv;
      rangeMaxMv <= next_rangeMaxMv;
    end
  end

  assign link.serialReadbackOut = sroOut;
  assign link.sroOe             = sroOe;
  assign link.integrityFlagN    = flagN;
endmodule

// *** dac_host_ctrl.sv ***
// Host end: frames commands onto the serial link and collects readback
`timescale 1ns/1ps
module dac_host_ctrl
  import dac_ctl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  dac_link_if.host                  link,
  input  wire logic                 cmdValid,
  input  wire logic [3:0]           cmdOp,
  input  wire logic [DATA_BITS-1:0] cmdData,
  output logic                      cmdReady,
  input  wire logic                 updateReq,
  input  wire logic                 clearReq,
  output logic                      rspValid,
  output logic      [DATA_BITS-1:0] rspData,
  output logic                      integrityOk
);
  host_state_e           state;
  host_state_e           next_state;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] next_frame;
  logic [5:0]            bitIdx;
  logic [5:0]            next_bitIdx;
  logic [7:0]            waitCnt;
  logic [7:0]            next_waitCnt;
  logic [DATA_BITS-1:0]  next_rspData;
  logic                  next_rspValid;
  logic                  selN;
  logic                  next_selN;
  logic                  sck;
  logic                  next_sck;
  logic                  sdi;
  logic                  next_sdi;
  logic                  updN;
  logic                  next_updN;
  logic                  clrN;
  logic [1:0]            sroSync;
  logic [1:0]            flagSync;
  logic                  waitDone;

  assign waitDone = waitCnt == 8'd0;

  always_comb begin
    next_state    = state;
    next_frame    = frame;
    next_bitIdx   = bitIdx;
    next_waitCnt  = waitDone ? 8'd0 : waitCnt - 8'd1;
    next_rspData  = rspData;
    next_rspValid = 1'b0;
    next_selN     = selN;
    next_sck      = sck;
    next_sdi      = sdi;
    next_updN     = updN;
    case (state)
      H_IDLE: begin
        if (cmdValid) begin
          next_frame   = {cmdOp, 4'h0, cmdData};
          next_bitIdx  = '0;
          next_selN    = 1'b0;
          next_sdi     = cmdOp[3];
          next_waitCnt = 8'(SCK_HALF_CYC - 1);
          next_state   = H_SETUP;
        end else if (updateReq) begin
          next_updN    = 1'b0;
          next_waitCnt = 8'(UPD_PULSE_CYC - 1);
          next_state   = H_UPD;
        end
      end
      H_SETUP, H_LOW: begin
        if (waitDone) begin
          next_sck     = 1'b1;
          if (bitIdx >= 6'(CMD_BITS))
            next_rspData = {rspData[DATA_BITS-2:0], sroSync[1]};
          next_waitCnt = 8'(SCK_HALF_CYC - 1);
          next_state   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (waitDone) begin
          next_sck     = 1'b0;
          next_bitIdx  = bitIdx + 6'd1;
          next_frame   = {frame[FRAME_BITS-2:0], 1'b0};
          next_sdi     = frame[FRAME_BITS-2];
          next_waitCnt = 8'(SCK_HALF_CYC - 1);
          next_state   = (bitIdx == 6'(FRAME_BITS - 1)) ? H_HOLD : H_LOW;
        end
      end
      H_HOLD: begin
        if (waitDone) begin
          next_selN    = 1'b1;
          next_sdi     = 1'b0;
          next_waitCnt = 8'(GAP_CYC - 1);
          next_state   = H_GAP;
        end
      end
      H_GAP: begin
        if (waitDone) begin
          next_rspValid = 1'b1;
          next_state    = H_IDLE;
        end
      end
      H_UPD: begin
        if (waitDone) begin
          next_updN  = 1'b1;
          next_state = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= H_IDLE;
      frame       <= '0;
      bitIdx      <= '0;
      waitCnt     <= '0;
      rspData     <= '0;
      rspValid    <= 1'b0;
      selN        <= 1'b1;
      sck         <= 1'b0;
      sdi         <= 1'b0;
      updN        <= 1'b1;
      clrN        <= 1'b1;
      cmdReady    <= 1'b0;
      sroSync     <= 2'h0;
      flagSync    <= 2'h0;
      integrityOk <= 1'b0;
    end else begin
      state       <= next_state;
      frame       <= next_frame;
      bitIdx      <= next_bitIdx;
      waitCnt     <= next_waitCnt;
      rspData     <= next_rspData;
      rspValid    <= next_rspValid;
      selN        <= next_selN;
      sck         <= next_sck;
      sdi         <= next_sdi;
      updN        <= next_updN;
      clrN        <= ~clearReq;
      cmdReady    <= (next_state == H_IDLE);
      sroSync     <= {sroSync[0], link.serialReadbackOut};
      flagSync    <= {flagSync[0], link.integrityFlagN};
      integrityOk <= flagSync[1];
    end
  end

  assign link.selectLoadN  = selN;
  assign link.sck          = sck;
  assign link.sdi          = sdi;
  assign link.asyncUpdateN = updN;
  assign link.systemClearN = clrN;
endmodule

// *** dac_link_props.sv ***
// Assertions on the serial link between the host and device ends
`timescale 1ns/1ps
module dac_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic selectLoadN,
  input wire logic sck,
  input wire logic sdi,
  input wire logic serialReadbackOut,
  input wire logic sroOe,
  input wire logic asyncUpdateN,
  input wire logic systemClearN,
  input wire logic integrityFlagN
);
  logic [3:0] evtAge;
  logic [3:0] next_evtAge;
  logic       selPrev;
  logic       updPrev;

  // Cycles since the last frame end or update pin fall
  always_comb begin
    next_evtAge = evtAge;
    if (evtAge != 4'hf)
      next_evtAge = evtAge + 4'h1;
    if ((selectLoadN && !selPrev) || (!asyncUpdateN && updPrev))
      next_evtAge = 4'h0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtAge  <= 4'hf;
      selPrev <= 1'b1;
      updPrev <= 1'b1;
    end else begin
      evtAge  <= next_evtAge;
      selPrev <= selectLoadN;
      updPrev <= asyncUpdateN;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_float_a: assert property (
    selectLoadN [*8] |-> !sroOe)
    else $error("readback driven while deselected");
  low_lead_a: assert property (
    $fell(selectLoadN) |-> ##[3:5] (sroOe && !serialReadbackOut))
    else $error("readback not driven low after select");
  drive_held_a: assert property (
    !selectLoadN [*8] |-> sroOe)
    else $error("readback released inside frame");
  clear_flag_a: assert property (
    !systemClearN [*6] |-> !integrityFlagN)
    else $error("flag high during clear");
  flag_release_a: assert property (
    $rose(integrityFlagN) |-> evtAge < 4'ha)
    else $error("flag released without update");
  rb_timing_a: assert property (
    sroOe && $past(sroOe) && $changed(serialReadbackOut) |->
      ($past(sck, 6) && !$past(sck, 5)) ||
      ($past(sck, 5) && !$past(sck, 4)) ||
      ($past(sck, 4) && !$past(sck, 3)))
    else $error("readback changed away from clock fall");
  sck_idle_a: assert property (
    selectLoadN |-> !sck)
    else $error("serial clock high while deselected");
  sdi_setup_a: assert property (
    $changed(sdi) |-> !sck)
    else $error("data changed while clock high");
  upd_locked_a: assert property (
    !asyncUpdateN |-> selectLoadN)
    else $error("update pin low inside frame");
  upd_width_a: assert property (
    $fell(asyncUpdateN) |-> !asyncUpdateN [*8] ##1 asyncUpdateN)
    else $error("update pulse width wrong");
endmodule

// *** tb_dac_range_code_control.sv ***
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb_dac_range_code_control
  import dac_ctl_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cmdValid = 1'b0;
  logic [3:0]         cmdOp = 4'h0;
  logic [23:0]        cmdData = 24'h000000;
  logic               updateReq = 1'b0;
  logic               clearReq = 1'b0;
  logic               manualSpan = 1'b0;
  logic [3:0]         strap = 4'h0;
  logic               supplyLow = 1'b0;
  logic               cmdReady;
  logic               rspValid;
  logic [23:0]        rspData;
  logic               integrityOk;
  logic [17:0]        dacCode;
  logic [3:0]         dacSpan;
  logic signed [15:0] rangeMinMv;
  logic signed [15:0] rangeMaxMv;
  logic [23:0]        rd;
  int                 fails = 0;
  int                 compares = 0;
  int                 cyc = 0;
  logic [15:0] loMv [6] = '{16'h0000, 16'h0000, 16'hec78, 16'hd8f0,
                            16'hf63c, 16'hf63c};
  logic [15:0] hiMv [6] = '{16'h1388, 16'h2710, 16'h1388, 16'h2710,
                            16'h09c4, 16'h1d4c};

  dac_link_if link ();
  dac_range_code_control u_dac_range_code_control (
    .clk(clk), .rst(rst), .link(link), .manualSpan(manualSpan),
    .rangeCodeBit3(strap[3]), .rangeCodeBit2(strap[2]),
    .rangeCodeBit1(strap[1]), .rangeCodeBit0(strap[0]),
    .supplyLow(supplyLow), .dacCode(dacCode), .dacSpan(dacSpan),
    .rangeMinMv(rangeMinMv), .rangeMaxMv(rangeMaxMv));
  dac_host_ctrl u_dac_host_ctrl (
    .clk(clk), .rst(rst), .link(link), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdData(cmdData), .cmdReady(cmdReady),
    .updateReq(updateReq), .clearReq(clearReq), .rspValid(rspValid),
    .rspData(rspData), .integrityOk(integrityOk));
  dac_link_props u_dac_link_props (
    .clk(clk), .rst(rst), .selectLoadN(link.selectLoadN),
    .sck(link.sck), .sdi(link.sdi),
    .serialReadbackOut(link.serialReadbackOut), .sroOe(link.sroOe),
    .asyncUpdateN(link.asyncUpdateN), .systemClearN(link.systemClearN),
    .integrityFlagN(link.integrityFlagN));

  always #5 clk = ~clk;

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well above the expected run of about 15000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkState(input logic [17:0] c, input logic [3:0] s);
    chk("dacCode", {6'h00, c}, {6'h00, dacCode});
    chk("dacSpan", {20'h00000, s}, {20'h00000, dacSpan});
  endtask

  task automatic chkFlag(input logic e);
    chk("integrityOk", {23'h000000, e}, {23'h000000, integrityOk});
  endtask

  task automatic chkRange(input int i);
    chk("rangeMinMv", {8'h00, loMv[i]}, {8'h00, rangeMinMv});
    chk("rangeMaxMv", {8'h00, hiMv[i]}, {8'h00, rangeMaxMv});
  endtask

  // Raise the command for the one edge at which the host is idle
  task automatic issue(input logic [3:0] op, input logic [23:0] d);
    #1;
    while (cmdReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmdOp <= op;
    cmdData <= d;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
  endtask

  task automatic send(input logic [3:0] op, input logic [23:0] d);
    int n;
    issue(op, d);
    n = 0;
    #1;
    while (rspValid !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("rspValid", 24'h000001, {23'h000000, rspValid});
    rd = rspData;
  endtask

  task automatic t_power();
    #1;
    chkState(18'h00000, 4'h0);
    chkRange(0);
    chkFlag(1'b0);
    send(CMD_NOP, 24'h000000);
    chk("rd", 24'h000000, rd);
    $display("t_power done");
  endtask

  task automatic t_write();
    send(CMD_WR_SPAN, 24'h000200);
    send(CMD_WR_CODE, 24'h800000);
    chk("rd", 24'h000200, rd);
    chkState(18'h00000, 4'h0);
    send(CMD_UPDATE, 24'h000000);
    chk("rd", 24'h800000, rd);
    chkState(18'h20000, 4'h2);
    chkFlag(1'b1);
    send(CMD_NOP, 24'h000000);
    chk("rd", 24'h000200, rd);
    $display("t_write done");
  endtask

  task automatic t_spans();
    for (int i = 0; i < 6; i++) begin
      send(CMD_WSPAN_UP, {12'h000, 4'(i), 8'h00});
      chkState(18'h20000, 4'(i));
      chkRange(i);
    end
    $display("t_spans done");
  endtask

  task automatic t_readback();
    logic [3:0] ops [4] = '{CMD_RD_ISPAN, CMD_RD_ICODE, CMD_RD_DSPAN,
                            CMD_RD_DCODE};
    logic [23:0] ex [4] = '{24'h000500, 24'h400000, 24'h000500,
                            24'h400000};
    send(CMD_WCODE_UP, 24'h400000);
    chkState(18'h10000, 4'h5);
    for (int i = 0; i < 4; i++) begin
      send(ops[i], 24'h000000);
      chk("rd", ex[i], rd);
    end
    send(4'h8, 24'hfffc00);
    send(CMD_WR_SPAN, 24'h000900);
    chk("rd", 24'h400000, rd);
    send(CMD_RD_ISPAN, 24'h000000);
    chk("rd", 24'h000500, rd);
    chkState(18'h10000, 4'h5);
    $display("t_readback done");
  endtask

  task automatic t_clear();
    send(CMD_WR_CODE, 24'hc00000);
    @(posedge clk);
    clearReq <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chkState(18'h00000, 4'h0);
    chkFlag(1'b0);
    @(posedge clk);
    clearReq <= 1'b0;
    send(CMD_NOP, 24'h000000);
    chk("rd", 24'h000000, rd);
    @(posedge clk);
    updateReq <= 1'b1;
    @(posedge clk);
    updateReq <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chkState(18'h30000, 4'h5);
    chkFlag(1'b1);
    $display("t_clear done");
  endtask

  task automatic t_abort();
    issue(CMD_WCODE_UP, 24'h800000);
    repeat (200) @(posedge clk);
    clearReq <= 1'b1;
    repeat (20) @(posedge clk);
    clearReq <= 1'b0;
    repeat (400) @(posedge clk);
    #1;
    chkState(18'h00000, 4'h0);
    send(CMD_WCODE_UP, 24'h400000);
    chkState(18'h10000, 4'h5);
    $display("t_abort done");
  endtask

  task automatic t_manual();
    @(posedge clk);
    manualSpan <= 1'b1;
    strap <= 4'h3;
    send(CMD_UPDATE, 24'h000000);
    chkState(18'h10000, 4'h3);
    chkRange(3);
    @(posedge clk);
    manualSpan <= 1'b0;
    supplyLow <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chkFlag(1'b0);
    send(CMD_UPDATE, 24'h000000);
    chkFlag(1'b0);
    @(posedge clk);
    supplyLow <= 1'b0;
    send(CMD_UPDATE, 24'h000000);
    chkFlag(1'b1);
    chkState(18'h10000, 4'h5);
    $display("t_manual done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_write();
    t_spans();
    t_readback();
    t_clear();
    t_abort();
    t_manual();
    wrap_up();
  end
endmodule
